// >>> hdl/pcb_counter.v
/*
 Preset counter mode control, teaching, scaling, outputs and batch counter.
 Assumes keypad and field inputs arrive asynchronously and an Avalon-MM
 master on CORE_CLK reaches the registers.
*/
// Implementation choices: the Avalon-MM slave port and the address map.
// Contract
// - scale factor 0.001 to 99.999
// - key lock level steps one to four
// - setting edits apply on run entry
// - teaching forces first and final outputs to inactive state
// - learn key ignored while counter off
// - six digit keys increment their digit
// - mode enters settings, display returns run
// - counting continues in setting mode
// - mode key locked under key protection
// - scale learn_key starts zero, digit clears count
// - taught scale is reference over count magnitude
// - round off, upward for negative values
// - learn key stores count as preset
// - batch counts final preset coincidences
// - batch count zero while batch reset
// - batch preset zero gives no output
// - batch count wraps past 9999
// - batch untouched by main reset
// - one-shot width 10 ms to 1 s
// - reset input width 1 or 20 ms
// - selectable count input filter
`timescale 1ns/10ps
`default_nettype none
`include "pcb_map.vh"
module pcb_counter #(
	parameter [6:0] CYC_PER_US = `PCB_CLK_MHZ
) (
	// clock, reset, enable
	input  wire        CORE_CLK,
	input  wire        RST_B,
	input  wire        CLK_EN,
	// register bus
	input  wire [5:0]  AVS_ADDRESS,
	input  wire        AVS_READ,
	input  wire        AVS_WRITE,
	input  wire [31:0] AVS_WRITEDATA,
	output reg  [31:0] AVS_READDATA,
	output reg         AVS_WAITREQUEST,
	// keypad
	input  wire [5:0]  KEY_DIGIT,
	input  wire        KEY_MODE,
	input  wire        KEY_DISPLAY,
	input  wire        KEY_LEARN,
	input  wire        KEY_RESET,
	input  wire        KEY_LOCK,
	// field inputs
	input  wire        COUNT_INPUT_A,
	input  wire        COUNT_INPUT_B,
	input  wire        RESET_IN,
	input  wire        BATCH_RESET_IN,
	// outputs
	output reg         OUT_FIRST,
	output reg         OUT_FINAL,
	output reg         OUT_BATCH
);
	localparam [2:0] ST_RUN = 3'h1;
	localparam [2:0] ST_FUNC = 3'h2;
	localparam [2:0] ST_LEARN_KEY = 3'h4;

	function [23:0] pow10;
		input [2:0] i;
		begin
			case (i)
				3'h0: pow10 = 24'h000001;
				3'h1: pow10 = 24'h00000a;
				3'h2: pow10 = 24'h000064;
				3'h3: pow10 = 24'h0003e8;
				3'h4: pow10 = 24'h002710;
				default: pow10 = 24'h0186a0;
			endcase
		end
	endfunction

	// one decimal digit up, nine wraps to zero
	function [23:0] inc_digit;
		input [23:0] v;
		input [2:0] i;
		reg [23:0] p;
		begin
			p = pow10(i);
			if (((v / p) % 24'h00000a) == 24'h000009)
				inc_digit = v - 24'h000009 * p;
			else
				inc_digit = v + p;
		end
	endfunction

	function [2:0] first_idx;
		input [5:0] k;
		begin
			if (k[0]) first_idx = 3'h0;
			else if (k[1]) first_idx = 3'h1;
			else if (k[2]) first_idx = 3'h2;
			else if (k[3]) first_idx = 3'h3;
			else if (k[4]) first_idx = 3'h4;
			else first_idx = 3'h5;
		end
	endfunction

	function [4:0] lock_bits;
		input [1:0] lv;
		begin
			case (lv)
				2'h0: lock_bits = `PCB_LOCK_L1;
				2'h1: lock_bits = `PCB_LOCK_L2;
				2'h2: lock_bits = `PCB_LOCK_L3;
				default: lock_bits = `PCB_LOCK_L4;
			endcase
		end
	endfunction

	function [19:0] os_len;
		input [2:0] s;
		begin
			case (s)
				3'h1: os_len = `PCB_OS_10MS_US;
				3'h2: os_len = `PCB_OS_50MS_US;
				3'h3: os_len = `PCB_OS_100MS_US;
				3'h4: os_len = `PCB_OS_200MS_US;
				3'h5: os_len = `PCB_OS_500MS_US;
				default: os_len = `PCB_OS_1000MS_US;
			endcase
		end
	endfunction

	reg [14:0] sync1_reg;
	reg [14:0] sync2_reg;
	reg [9:0]  key_prev_reg;
	reg [6:0]  us_div_reg;
	reg        fa_reg;
	reg        fb_reg;
	reg [13:0] fca_reg;
	reg [13:0] fcb_reg;
	reg        up_reg;
	reg        dn_reg;
	reg [14:0] rst_cnt_reg;
	reg        rst_q_reg;
	reg [2:0]  state_reg;
	reg [2:0]  item_reg;
	reg        edit_sel_reg;
	reg        ctrl_on_reg;
	reg        two_reg;
	reg        coff_reg;
	reg [16:0] pend_scale_reg;
	reg [16:0] act_scale_reg;
	reg [1:0]  pend_lock_reg;
	reg [1:0]  act_lock_reg;
	reg        pend_slow_reg;
	reg        act_slow_reg;
	reg        pend_rst20_reg;
	reg        act_rst20_reg;
	reg [2:0]  pend_os_reg;
	reg [2:0]  act_os_reg;
	reg [23:0] preset1_reg;
	reg [23:0] preset2_reg;
	reg [13:0] bpreset_reg;
	reg [23:0] present_reg;
	reg [13:0] batch_reg;
	reg [23:0] ref_reg;
	reg [16:0] learn_key_sf_reg;
	reg        learn_key_show_reg;
	reg [19:0] os_reg;
	reg        final_prev_reg;
	reg [31:0] rd_next;

	// microsecond tick and key handling
	wire        us_tick = (us_div_reg == CYC_PER_US - 7'h01);
	wire [9:0]  key_edge = sync2_reg[9:0] & ~key_prev_reg;
	wire [4:0]  lock_mask = sync2_reg[10] ? lock_bits(act_lock_reg) : 5'h00;
	wire [2:0]  dig_idx = first_idx(key_edge[5:0]);
	wire        k_digit = (|key_edge[5:0]) & ~lock_mask[4];
	wire        k_mode = key_edge[6] & ~lock_mask[0];
	wire        k_disp = key_edge[7] & ~lock_mask[1];
	wire        k_learn = key_edge[8] & ~lock_mask[2] & ctrl_on_reg;
	wire        k_reset = key_edge[9] & ~lock_mask[3];
	wire        in_run = state_reg[0];
	wire        in_func = state_reg[1];
	wire        in_learn_key = state_reg[2];

	// bus decode
	wire        wr_go = AVS_WRITE & ~AVS_WAITREQUEST;
	wire        sw_rst = wr_go & (AVS_ADDRESS == `PCB_CTRL_OFS) &
		AVS_WRITEDATA[`PCB_CTRL_SWRST];
	wire        main_rst = k_reset | rst_q_reg | sw_rst;

	// scaled value, round half up, negative truncates upward
	wire signed [47:0] prod = $signed({{24{present_reg[23]}}, present_reg}) *
		$signed({31'h00000000, act_scale_reg});
	wire signed [47:0] scaled48 = prod[47] ? prod / 48'sh0003e8 :
		(prod + 48'sh0001f4) / 48'sh0003e8;
	wire [31:0] scaled = scaled48[31:0];
	wire [31:0] scaled_mag = scaled[31] ? 32'h00000000 - scaled : scaled;
	wire        match1 = $signed(scaled) >= $signed({8'h00, preset1_reg});
	wire        match2 = $signed(scaled) >= $signed({8'h00, preset2_reg});

	// taught scale from reference and count magnitude
	wire        neg = present_reg[23];
	wire [23:0] mag = neg ? 24'h000000 - present_reg : present_reg;
	wire [39:0] den = (mag == 24'h000000) ? 40'h0000000001 : {16'h0000, mag};
	wire [39:0] num = {16'h0000, ref_reg} * 40'h00000003e8;
	wire [39:0] tq = neg ? (num + den - 40'h0000000001) / den :
		(num + {1'b0, den[39:1]}) / den;
	wire [16:0] tq_clamp = (tq > {23'h000000, `PCB_SCALE_MAX}) ? `PCB_SCALE_MAX :
		(tq == 40'h0000000000) ? `PCB_SCALE_MIN : tq[16:0];

	// value under edit by the digit keys
	wire [23:0] edit_src = in_learn_key ? ref_reg :
		in_func ? {7'h00, pend_scale_reg} :
		edit_sel_reg ? preset2_reg : preset1_reg;
	wire [23:0] edit_inc = inc_digit(edit_src, dig_idx);
	wire        learn_key_clr = in_learn_key & (item_reg == 3'h0) & k_digit &
		~k_disp & ~k_mode & ~k_learn;
	wire [13:0] flim = act_slow_reg ? `PCB_FILT_SLOW_US : `PCB_FILT_FAST_US;
	wire [14:0] rlim = act_rst20_reg ? `PCB_RST_20MS_US : `PCB_RST_1MS_US;
	wire        final_hit = match2 & ~final_prev_reg;

	// synchronisers, filters, reset qualification
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			sync1_reg <= 15'h0000;
			sync2_reg <= 15'h0000;
			key_prev_reg <= 10'h000;
			us_div_reg <= 7'h00;
			fa_reg <= 1'b0;
			fb_reg <= 1'b0;
			fca_reg <= 14'h0000;
			fcb_reg <= 14'h0000;
			up_reg <= 1'b0;
			dn_reg <= 1'b0;
			rst_cnt_reg <= 15'h0000;
			rst_q_reg <= 1'b0;
		end else if (CLK_EN) begin
			sync1_reg <= {BATCH_RESET_IN, RESET_IN, COUNT_INPUT_B, COUNT_INPUT_A,
				KEY_LOCK, KEY_RESET, KEY_LEARN, KEY_DISPLAY, KEY_MODE, KEY_DIGIT};
			sync2_reg <= sync1_reg;
			key_prev_reg <= sync2_reg[9:0];
			us_div_reg <= us_tick ? 7'h00 : us_div_reg + 7'h01;
			up_reg <= 1'b0;
			dn_reg <= 1'b0;
			// input a filter, short pulses rejected
			if (sync2_reg[11] == fa_reg)
				fca_reg <= 14'h0000;
			else if (us_tick && fca_reg >= flim) begin
				fa_reg <= sync2_reg[11];
				up_reg <= sync2_reg[11];
				fca_reg <= 14'h0000;
			end else if (us_tick)
				fca_reg <= fca_reg + 14'h0001;
			// input b filter, same setting as a
			if (sync2_reg[12] == fb_reg)
				fcb_reg <= 14'h0000;
			else if (us_tick && fcb_reg >= flim) begin
				fb_reg <= sync2_reg[12];
				dn_reg <= sync2_reg[12];
				fcb_reg <= 14'h0000;
			end else if (us_tick)
				fcb_reg <= fcb_reg + 14'h0001;
			// reset input minimum width
			if (!sync2_reg[13])
				rst_cnt_reg <= 15'h0000;
			else if (us_tick && rst_cnt_reg < rlim)
				rst_cnt_reg <= rst_cnt_reg + 15'h0001;
			rst_q_reg <= sync2_reg[13] && (rst_cnt_reg >= rlim);
		end
	end

	// modes, settings, counting, outputs, bus
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state_reg <= ST_RUN;
			item_reg <= 3'h0;
			edit_sel_reg <= 1'b0;
			ctrl_on_reg <= 1'b1;
			two_reg <= 1'b0;
			coff_reg <= 1'b0;
			pend_scale_reg <= `PCB_SCALE_RST;
			act_scale_reg <= `PCB_SCALE_RST;
			pend_lock_reg <= 2'h0;
			act_lock_reg <= 2'h0;
			pend_slow_reg <= 1'b0;
			act_slow_reg <= 1'b0;
			pend_rst20_reg <= 1'b0;
			act_rst20_reg <= 1'b0;
			pend_os_reg <= 3'h0;
			act_os_reg <= 3'h0;
			preset1_reg <= 24'h000000;
			preset2_reg <= 24'h000000;
			bpreset_reg <= 14'h0000;
			present_reg <= 24'h000000;
			batch_reg <= 14'h0000;
			ref_reg <= 24'h000000;
			learn_key_sf_reg <= 17'h00000;
			learn_key_show_reg <= 1'b0;
			os_reg <= 20'h00000;
			final_prev_reg <= 1'b0;
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA <= 32'h00000000;
			OUT_FIRST <= 1'b0;
			OUT_FINAL <= 1'b0;
			OUT_BATCH <= 1'b0;
		end else if (CLK_EN) begin
			case (state_reg)
				ST_RUN: begin
					if (k_mode) begin
						state_reg <= ST_FUNC;
						item_reg <= 3'h0;
					end else if (k_learn) begin
						state_reg <= ST_LEARN_KEY;
						item_reg <= 3'h0;
						learn_key_sf_reg <= 17'h00000;
						ref_reg <= 24'h000000;
					end else if (k_disp)
						edit_sel_reg <= ~edit_sel_reg;
					else if (k_digit && edit_sel_reg)
						preset2_reg <= edit_inc;
					else if (k_digit)
						preset1_reg <= edit_inc;
				end
				ST_FUNC: begin
					if (k_disp)
						state_reg <= ST_RUN;
					else if (k_mode)
						item_reg <= (item_reg == 3'h4) ? 3'h0 : item_reg + 3'h1;
					else if (k_digit) begin
						case (item_reg)
							3'h0: if (dig_idx != 3'h5) pend_scale_reg <= edit_inc[16:0];
							3'h1: pend_lock_reg <= pend_lock_reg + 2'h1;
							3'h2: pend_slow_reg <= ~pend_slow_reg;
							3'h3: pend_rst20_reg <= ~pend_rst20_reg;
							default: pend_os_reg <= (pend_os_reg == `PCB_OS_LAST) ?
								3'h0 : pend_os_reg + 3'h1;
						endcase
					end
				end
				default: begin
					if (k_disp)
						state_reg <= ST_RUN;
					else if (k_mode) begin
						if (item_reg == 3'h0)
							item_reg <= two_reg ? 3'h1 : 3'h2;
						else
							item_reg <= (item_reg == 3'h1) ? 3'h2 : 3'h0;
					end else if (k_learn) begin
						if (item_reg == 3'h0 && mag != 24'h000000) begin
							learn_key_sf_reg <= tq_clamp;
							pend_scale_reg <= tq_clamp;
						end else if (item_reg == 3'h1)
							preset1_reg <= scaled_mag[23:0];
						else if (item_reg == 3'h2)
							preset2_reg <= scaled_mag[23:0];
					end else if (learn_key_clr)
						ref_reg <= edit_inc;
				end
			endcase
			learn_key_show_reg <= in_learn_key & (item_reg == 3'h0) & sync2_reg[8];
			// pending settings become active only in run mode
			if (in_run) begin
				if (pend_scale_reg != 17'h00000)
					act_scale_reg <= pend_scale_reg;
				act_lock_reg <= pend_lock_reg;
				act_slow_reg <= pend_slow_reg;
				act_rst20_reg <= pend_rst20_reg;
				act_os_reg <= pend_os_reg;
			end
			// counting runs in every mode
			if (main_rst || learn_key_clr)
				present_reg <= 24'h000000;
			else if (ctrl_on_reg && (up_reg ^ dn_reg))
				present_reg <= up_reg ? present_reg + 24'h000001 :
					present_reg - 24'h000001;
			// batch counter, free of the main reset
			final_prev_reg <= match2;
			if (sync2_reg[14])
				batch_reg <= 14'h0000;
			else if (final_hit)
				batch_reg <= (batch_reg == `PCB_BATCH_MAX) ?
					14'h0000 : batch_reg + 14'h0001;
			OUT_BATCH <= (bpreset_reg != 14'h0000) && (batch_reg >= bpreset_reg);
			// one-shot timer on the final output
			if (main_rst)
				os_reg <= 20'h00000;
			else if (final_hit && act_os_reg != 3'h0)
				os_reg <= os_len(act_os_reg);
			else if (us_tick && os_reg != 20'h00000)
				os_reg <= os_reg - 20'h00001;
			// control outputs, forced while teaching
			OUT_FIRST <= in_learn_key ? coff_reg : (two_reg & match1) ^ coff_reg;
			if (in_learn_key)
				OUT_FINAL <= coff_reg;
			else if (act_os_reg == 3'h0)
				OUT_FINAL <= match2 ^ coff_reg;
			else
				OUT_FINAL <= (os_reg != 20'h00000) ^ coff_reg;
			// bus handshake, one wait cycle per access
			if (!AVS_WAITREQUEST)
				AVS_WAITREQUEST <= 1'b1;
			else if (AVS_READ || AVS_WRITE) begin
				AVS_WAITREQUEST <= 1'b0;
				// read data only moves on a read
				if (AVS_READ)
					AVS_READDATA <= rd_next;
			end
			if (wr_go) begin
				if (AVS_ADDRESS == `PCB_CTRL_OFS) begin
					ctrl_on_reg <= AVS_WRITEDATA[`PCB_CTRL_ENA];
					two_reg <= AVS_WRITEDATA[`PCB_CTRL_TWO];
					coff_reg <= AVS_WRITEDATA[`PCB_CTRL_COFF];
				end else if (AVS_ADDRESS == `PCB_SCALE_OFS) begin
					if (AVS_WRITEDATA[16:0] <= `PCB_SCALE_MAX)
						pend_scale_reg <= AVS_WRITEDATA[16:0];
				end else if (AVS_ADDRESS == `PCB_OPTS_OFS) begin
					pend_lock_reg <= AVS_WRITEDATA[`PCB_OPT_LOCK+1:`PCB_OPT_LOCK];
					pend_slow_reg <= AVS_WRITEDATA[`PCB_OPT_SLOW];
					pend_rst20_reg <= AVS_WRITEDATA[`PCB_OPT_RST20];
					if (AVS_WRITEDATA[`PCB_OPT_OS+2:`PCB_OPT_OS] <= `PCB_OS_LAST)
						pend_os_reg <= AVS_WRITEDATA[`PCB_OPT_OS+2:`PCB_OPT_OS];
				end else if (AVS_ADDRESS == `PCB_PRESET1_OFS) begin
					preset1_reg <= AVS_WRITEDATA[23:0];
				end else if (AVS_ADDRESS == `PCB_PRESET2_OFS) begin
					preset2_reg <= AVS_WRITEDATA[23:0];
				end else if (AVS_ADDRESS == `PCB_BPRESET_OFS) begin
					bpreset_reg <= AVS_WRITEDATA[13:0];
				end
			end
		end
	end

	// read data mux, unmapped reads zero
	always @* begin
		rd_next = 32'h00000000;
		if (AVS_ADDRESS == `PCB_CTRL_OFS)
			rd_next = {29'h00000000, coff_reg, two_reg, ctrl_on_reg};
		else if (AVS_ADDRESS == `PCB_SCALE_OFS)
			rd_next = {15'h0000, pend_scale_reg};
		else if (AVS_ADDRESS == `PCB_OPTS_OFS)
			rd_next = {25'h0000000, pend_os_reg, pend_rst20_reg, pend_slow_reg,
				pend_lock_reg};
		else if (AVS_ADDRESS == `PCB_PRESET1_OFS)
			rd_next = {8'h00, preset1_reg};
		else if (AVS_ADDRESS == `PCB_PRESET2_OFS)
			rd_next = {8'h00, preset2_reg};
		else if (AVS_ADDRESS == `PCB_BPRESET_OFS)
			rd_next = {18'h00000, bpreset_reg};
		else if (AVS_ADDRESS == `PCB_PRESENT_OFS)
			rd_next = {{8{present_reg[23]}}, present_reg};
		else if (AVS_ADDRESS == `PCB_SCALED_OFS)
			rd_next = scaled;
		else if (AVS_ADDRESS == `PCB_BCOUNT_OFS)
			rd_next = {18'h00000, batch_reg};
		else if (AVS_ADDRESS == `PCB_STATUS_OFS)
			rd_next = {20'h00000, act_scale_reg == pend_scale_reg, edit_sel_reg,
				learn_key_show_reg, OUT_BATCH, OUT_FINAL, OUT_FIRST, item_reg, state_reg};
		else if (AVS_ADDRESS == `PCB_TSCALE_OFS)
			rd_next = {15'h0000, learn_key_sf_reg};
		else if (AVS_ADDRESS == `PCB_REF_OFS)
			rd_next = {8'h00, ref_reg};
	end
endmodule
`default_nettype wire

// >>> include/pcb_map.vh
/*
 Constants for the preset counter mode and batch block: register byte
 offsets, field positions, reset values, key-lock masks and times.
 Assumes inclusion by its bare name from the design file.
*/
`ifndef PCB_MAP_VH
`define PCB_MAP_VH
// clock rate, cycles per microsecond tick
`define PCB_CLK_MHZ 7'h7d
// register byte offsets
`define PCB_CTRL_OFS    6'h00
`define PCB_SCALE_OFS   6'h04
`define PCB_OPTS_OFS    6'h08
`define PCB_PRESET1_OFS 6'h0c
`define PCB_PRESET2_OFS 6'h10
`define PCB_BPRESET_OFS 6'h14
`define PCB_PRESENT_OFS 6'h18
`define PCB_SCALED_OFS  6'h1c
`define PCB_BCOUNT_OFS  6'h20
`define PCB_STATUS_OFS  6'h24
`define PCB_TSCALE_OFS  6'h28
`define PCB_REF_OFS     6'h2c
// control fields
`define PCB_CTRL_ENA   0
`define PCB_CTRL_TWO   1
`define PCB_CTRL_COFF  2
`define PCB_CTRL_SWRST 3
// option fields
`define PCB_OPT_LOCK  0
`define PCB_OPT_SLOW  2
`define PCB_OPT_RST20 3
`define PCB_OPT_OS    4
// reset values and limits
`define PCB_SCALE_RST 17'h003e8
`define PCB_SCALE_MIN 17'h00001
`define PCB_SCALE_MAX 17'h1869f
`define PCB_BATCH_MAX 14'h270f
`define PCB_OS_LAST   3'h6
// lock masks {digit,reset,learn,display,mode}
`define PCB_LOCK_L1 5'h1f
`define PCB_LOCK_L2 5'h0d
`define PCB_LOCK_L3 5'h11
`define PCB_LOCK_L4 5'h01
// times in microsecond ticks
`define PCB_FILT_FAST_US 14'h0014
`define PCB_FILT_SLOW_US 14'h3a98
`define PCB_RST_1MS_US   15'h03e8
`define PCB_RST_20MS_US  15'h4e20
`define PCB_OS_10MS_US   20'h02710
`define PCB_OS_50MS_US   20'h0c350
`define PCB_OS_100MS_US  20'h186a0
`define PCB_OS_200MS_US  20'h30d40
`define PCB_OS_500MS_US  20'h7a120
`define PCB_OS_1000MS_US 20'hf4240
`endif

// >>> tb/pcb_props.sv
/*
 Checker for the preset counter block: bus handshake and batch output.
 Assumes one clock domain, bound onto the counter's top module.
*/
`timescale 1ns/10ps
`default_nettype none
module pcb_props (
	// clock, reset, enable
	input wire logic        CORE_CLK,
	input wire logic        RST_B,
	input wire logic        CLK_EN,
	// register bus
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	// field side
	input wire logic        BATCH_RESET_IN,
	input wire logic        OUT_FIRST,
	input wire logic        OUT_FINAL,
	input wire logic        OUT_BATCH
);
	logic [5:0] cause_reg;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_B);
	// recent batch reset or bus write, the only causes other than the batch wrap past 9999 for batch output to drop
	always @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			cause_reg <= 6'h00;
		end else begin
			cause_reg <= {cause_reg[4:0], BATCH_RESET_IN | AVS_WRITE};
		end
	end
	a_wait_answer: assert property (CLK_EN && (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
		|=> !AVS_WAITREQUEST) else $error("bus request not answered after one wait");
	a_wait_single: assert property (CLK_EN && !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("wait low longer than one cycle");
	a_idle_wait: assert property (CLK_EN && !AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
		else $error("wait low without request");
	a_rdata_hold: assert property ($changed(AVS_READDATA)
		|-> !AVS_WAITREQUEST && $past(AVS_READ)) else $error("read data moved off a read");
	a_wdata_keep: assert property (CLK_EN && AVS_WRITE |=> $stable(AVS_READDATA))
		else $error("read data moved on a write");
	a_reset_quiet: assert property ($rose(RST_B)
		|-> AVS_WAITREQUEST && !OUT_FIRST && !OUT_FINAL && !OUT_BATCH)
		else $error("outputs not idle after reset");
	a_batch_held: assert property (BATCH_RESET_IN [*6] |-> !OUT_BATCH)
		else $error("batch output on during batch reset");
	a_batch_drop: assert property ($fell(OUT_BATCH) |-> |cause_reg)
		else $error("batch output dropped without batch reset or write");
	c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
	c_batch: cover property ($rose(OUT_BATCH));
	c_first: cover property ($rose(OUT_FIRST));
	c_final: cover property ($rose(OUT_FINAL));
endmodule
bind pcb_counter pcb_props u_props (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CLK_EN(CLK_EN),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .BATCH_RESET_IN(BATCH_RESET_IN),
	.OUT_FIRST(OUT_FIRST), .OUT_FINAL(OUT_FINAL), .OUT_BATCH(OUT_BATCH));
`default_nettype wire

// >>> tb/pcb_field.sv
/*
 Field model: a count sensor driving the two count lines.
 Assumes the bench calls pulses and the fast input filter is selected.
*/
`timescale 1ns/10ps
`default_nettype none
module pcb_field #(
	parameter int HOLD = 50
) (
	// clock
	input  wire logic clk,
	// count lines
	output var logic  cnt_a,
	output var logic  cnt_b
);
	initial begin
		cnt_a = 1'b0;
		cnt_b = 1'b0;
	end
	// high and low each held past the filter time
	// same timing on both lines
	task automatic pulses(input int n, input bit down);
		repeat (n) begin
			@(posedge clk);
			if (down) begin
				cnt_b <= 1'b1;
			end else begin
				cnt_a <= 1'b1;
			end
			repeat (HOLD) @(posedge clk);
			cnt_a <= 1'b0;
			cnt_b <= 1'b0;
			repeat (HOLD) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
/*
 Bench for the preset counter block: modes, teaching, scaling, batch.
 Assumes the design, its checker and the field model compile first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pcb_map.vh"
module tb_top;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [5:0]  adr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic [31:0] q;
	logic [9:0]  keys = 10'h000;
	logic        lock = 1'b0;
	logic        rst_in = 1'b0;
	logic        brst = 1'b0;
	logic        ce = 1'b1;
	wire  [31:0] rdata;
	wire         wreq, o_first, o_final, o_batch, cnt_a, cnt_b;
	int          fail_count = 0, check_count = 0, seed = 20353, e, v, k;
	always #4 clk = ~clk;
	pcb_counter #(.CYC_PER_US(7'h02)) dut (.CORE_CLK(clk), .RST_B(rst_b), .CLK_EN(ce),
		.AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq), .KEY_DIGIT(keys[5:0]),
		.KEY_MODE(keys[6]), .KEY_DISPLAY(keys[7]), .KEY_LEARN(keys[8]),
		.KEY_RESET(keys[9]), .KEY_LOCK(lock), .COUNT_INPUT_A(cnt_a),
		.COUNT_INPUT_B(cnt_b), .RESET_IN(rst_in), .BATCH_RESET_IN(brst),
		.OUT_FIRST(o_first), .OUT_FINAL(o_final), .OUT_BATCH(o_batch));
	pcb_field #(.HOLD(50)) fld (.clk(clk), .cnt_a(cnt_a), .cnt_b(cnt_b));
	function automatic int scl(int c, int s);
		return (c * s + 500) / 1000;
	endfunction
	function automatic int tch(int r, int c);
		return (r * 1000 + c / 2) / c;
	endfunction
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", nm, x, g);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (wreq !== 1'b0 && k < 64);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (k >= 64) begin
			fail_count++;
			$display("unexpected bus wait: expected 0 seen 1");
			conclude();
		end
	endtask
	task automatic rc(input string nm, input logic [5:0] a, input logic [31:0] m,
		input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		chk(nm, x, q & m);
	endtask
	task automatic wrt(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic key(input int i);
		@(posedge clk);
		keys[i] <= 1'b1;
		repeat (8) @(posedge clk);
		keys[i] <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		conclude();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		rc("ctrl", `PCB_CTRL_OFS, 32'hf, 32'h1);
		rc("scale", `PCB_SCALE_OFS, 32'h1ffff, 32'h3e8);
		rc("mode", `PCB_STATUS_OFS, 32'h7, 32'h1);
		wrt(6'h30, 32'h5);
		rc("unmapped", 6'h30, 32'hffffffff, 32'h0);
		e = 1000;
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 100000 : (i == 1) ? 99999 : (i == 2) ? 1
				: 1 + ($unsigned($random(seed)) % 99999);
			wrt(`PCB_SCALE_OFS, v);
			if (v <= 99999) e = v;
			rc("scale", `PCB_SCALE_OFS, 32'h1ffff, e);
			rc("applied", `PCB_STATUS_OFS, 32'h800, 32'h800);
		end
		$display("test reset and scale done");
		wrt(`PCB_SCALE_OFS, 2000);
		fld.pulses(3, 0);
		rc("count", `PCB_PRESENT_OFS, 32'hffffff, 3);
		rc("scaled", `PCB_SCALED_OFS, 32'hffffff, scl(3, 2000));
		key(6);
		rc("mode", `PCB_STATUS_OFS, 32'h7, 32'h2);
		wrt(`PCB_SCALE_OFS, 3000);
		fld.pulses(2, 0);
		rc("count", `PCB_PRESENT_OFS, 32'hffffff, 5);
		rc("scaled", `PCB_SCALED_OFS, 32'hffffff, scl(5, 2000));
		key(7);
		rc("mode", `PCB_STATUS_OFS, 32'h7, 32'h1);
		rc("scaled", `PCB_SCALED_OFS, 32'hffffff, scl(5, 3000));
		fld.pulses(1, 1);
		rc("count", `PCB_PRESENT_OFS, 32'hffffff, 4);
		ce <= 1'b0;
		fld.pulses(1, 0);
		ce <= 1'b1;
		rc("frozen", `PCB_PRESENT_OFS, 32'hffffff, 4);
		$display("test counting done");
		wrt(`PCB_OPTS_OFS, 3);
		lock <= 1'b1;
		key(6);
		rc("mode", `PCB_STATUS_OFS, 32'h7, 32'h1);
		key(0);
		rc("preset", `PCB_PRESET1_OFS, 32'hffffff, 1);
		wrt(`PCB_OPTS_OFS, 0);
		key(0);
		rc("preset", `PCB_PRESET1_OFS, 32'hffffff, 1);
		lock <= 1'b0;
		e = 1;
		for (int i = 0; i < 6; i++) begin
			key(i);
			e += 10 ** i;
			rc("digit", `PCB_PRESET1_OFS, 32'hffffff, e);
		end
		$display("test keys done");
		wrt(`PCB_CTRL_OFS, 0);
		key(8);
		rc("mode", `PCB_STATUS_OFS, 32'h7, 32'h1);
		wrt(`PCB_CTRL_OFS, 1);
		key(8);
		rc("mode", `PCB_STATUS_OFS, 32'h7, 32'h4);
		@(negedge clk);
		chk("outputs", 32'h0, {30'h0, o_first, o_final});
		rc("taught", `PCB_TSCALE_OFS, 32'h1ffff, 0);
		key(1);
		rc("count", `PCB_PRESENT_OFS, 32'hffffff, 0);
		fld.pulses(6, 0);
		key(8);
		rc("taught", `PCB_TSCALE_OFS, 32'h1ffff, tch(10, 6));
		key(6);
		key(8);
		rc("preset", `PCB_PRESET2_OFS, 32'hffffff, scl(6, 3000));
		key(7);
		$display("test teaching done");
		wrt(`PCB_SCALE_OFS, 1000);
		wrt(`PCB_PRESET2_OFS, 3);
		wrt(`PCB_BPRESET_OFS, 1);
		key(9);
		brst <= 1'b1;
		repeat (8) @(posedge clk);
		rc("batch", `PCB_BCOUNT_OFS, 32'h3fff, 0);
		brst <= 1'b0;
		fld.pulses(3, 0);
		rc("batch", `PCB_BCOUNT_OFS, 32'h3fff, 1);
		@(negedge clk);
		chk("batch out", 32'h1, {31'h0, o_batch});
		@(posedge clk);
		rst_in <= 1'b1;
		repeat (100) @(posedge clk);
		rst_in <= 1'b0;
		rc("count", `PCB_PRESENT_OFS, 32'hffffff, 3);
		rst_in <= 1'b1;
		repeat (2100) @(posedge clk);
		rst_in <= 1'b0;
		rc("count", `PCB_PRESENT_OFS, 32'hffffff, 0);
		rc("batch", `PCB_BCOUNT_OFS, 32'h3fff, 1);
		wrt(`PCB_BPRESET_OFS, 0);
		fld.pulses(3, 0);
		rc("batch", `PCB_BCOUNT_OFS, 32'h3fff, 2);
		@(negedge clk);
		chk("batch out", 32'h0, {31'h0, o_batch});
		wrt(`PCB_CTRL_OFS, 3);
		wrt(`PCB_PRESET1_OFS, 1);
		key(9);
		fld.pulses(1, 0);
		rc("batch", `PCB_BCOUNT_OFS, 32'h3fff, 2);
		@(negedge clk);
		chk("first out", 32'h1, {31'h0, o_first});
		fld.pulses(2, 0);
		rc("batch", `PCB_BCOUNT_OFS, 32'h3fff, 3);
		wrt(`PCB_OPTS_OFS, 32'h10);
		key(9);
		fld.pulses(3, 0);
		@(negedge clk);
		chk("one-shot", 32'h1, {31'h0, o_final});
		repeat (20000) @(posedge clk);
		@(negedge clk);
		chk("one-shot end", 32'h0, {31'h0, o_final});
		$display("test batch done");
		conclude();
	end
endmodule
`default_nettype wire
